// File: design/dtc_timer_ctrl.sv
// Purpose: control, mode and flag logic of two counter/timers and two
//          external interrupt inputs, behind a byte register port
// Assumes: pins synchronous-ish to i_mclk but resynchronised here anyway
// Notes:   clock control and polarity bits arrive as plain inputs
//
// Functional notes
// - overflow flags set on overflow, cleared by software or on vectoring
// - run bit one enables its timer, zero stops it
// - pending flags set on detected edge or level per type bit
// - software clears pending unless a set lands that cycle; vectoring clears only in edge mode
// - type bit zero selects level, one selects edge detection
// - per-input polarity bit decides active sense of interrupt input
// - gate set counts only with run and active interrupt input
// - gate clear counts whenever run is set
// - counter select one counts falling edges of external count pin, except timer1 while timer0 is split
// - counter select zero counts the internal clock chosen by clock select
// - timer1 mode field: 13-bit, 16-bit, 8-bit reload, inactive
// - timer0 same codes, code 11 splits into two 8-bit timers
// - mode register at address 0x89 on every page
// - control register bit-addressable and visible on every page
// - 13-bit mode uses eight high and five low bits, overflow at 0x1FFF
// - reload mode counts low byte, reloads from high byte on overflow
// - split timer0 high byte runs on timer1 run bit, sets timer1 flag
// - prescale field picks sysclk/12, /4, /48 or external clock/8
`timescale 1ns/10ps
`default_nettype none
module dtc_timer_ctrl #(
	parameter int SYNC_STAGES = 2
) (
	// clock and reset
	input  wire logic       i_mclk,
	input  wire logic       i_resetn,
	input  wire logic       i_ce,
	// register port
	input  wire logic [7:0] i_addr,
	input  wire logic       i_wr,
	input  wire logic       i_bit_wr,
	input  wire logic [2:0] i_bit_sel,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_rd,
	output logic      [7:0] o_rdata,
	// interrupt vectoring acknowledges
	input  wire logic       i_ack_timer0,
	input  wire logic       i_ack_timer1,
	input  wire logic       i_ack_ext0,
	input  wire logic       i_ack_ext1,
	// configuration held elsewhere
	input  wire logic       i_ext_irq0_polarity,
	input  wire logic       i_ext_irq1_polarity,
	input  wire logic       i_timer0_sysclk_select,
	input  wire logic       i_timer1_sysclk_select,
	input  wire logic [1:0] i_prescale_sel,
	// pins
	input  wire logic       i_ext_irq0_pin,
	input  wire logic       i_ext_irq1_pin,
	input  wire logic       i_timer0_ext_count_pin,
	input  wire logic       i_timer1_ext_count_pin,
	input  wire logic       i_ext_clk,
	// status
	output logic      [7:0] o_timer_ctrl,
	output logic            o_timer1_overflow
);
	if (SYNC_STAGES != 2) begin : g_bad_sync
		$error("only two sync stages supported");
	end

	////////////////////////////////////////////////////////////////////
	// input synchronisers and edge detect
	logic [4:0] pin_raw;
	logic [4:0] sync1_reg;
	logic [4:0] sync2_reg;
	logic [4:0] prev_reg;
	logic [4:0] fall;
	logic [4:0] rise;
	logic [2:0] prime_reg;
	assign pin_raw = {i_ext_clk, i_timer1_ext_count_pin,
		i_timer0_ext_count_pin, i_ext_irq1_pin, i_ext_irq0_pin};

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			prev_reg <= '0;
			prime_reg <= '0;
		end else if (i_ce) begin
			sync1_reg <= pin_raw;
			sync2_reg <= sync1_reg;
			prev_reg <= sync2_reg;
			prime_reg <= {prime_reg[1:0], 1'b1};
		end
	end
	// reset zeros in the chain would look like pin events, so wait for fill
	assign fall = prime_reg[2] ? (prev_reg & ~sync2_reg) : '0;
	assign rise = prime_reg[2] ? (~prev_reg & sync2_reg) : '0;

	// active level and activation edge of each interrupt input
	logic [1:0] irq_act;
	logic [1:0] irq_edge;
	logic [1:0] polarity;
	assign polarity = {i_ext_irq1_polarity, i_ext_irq0_polarity};
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_irq
			// polarity one means active high
			assign irq_act[g] = prime_reg[2]
				&& (polarity[g] ? sync2_reg[g] : ~sync2_reg[g]);
			assign irq_edge[g] = polarity[g] ? rise[g] : fall[g];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// prescaler
	logic pre_tick;
	dtc_prescaler #(
		.CNT_W(6)
	) u_pre (
		.i_mclk     (i_mclk),
		.i_resetn   (i_resetn),
		.i_ce       (i_ce),
		.i_sel      (i_prescale_sel),
		.i_ext_edge (rise[4]),
		.o_tick     (pre_tick)
	);

	////////////////////////////////////////////////////////////////////
	// registers
	logic [7:0] ctrl_reg, ctrl_next;
	logic [7:0] mode_reg, mode_next;
	logic [7:0] t0l_reg, t0l_next, t0h_reg, t0h_next;
	logic [7:0] t1l_reg, t1l_next, t1h_reg, t1h_next;
	logic [7:0] rdata_reg, rdata_next;
	logic       t1ovf_reg, t1ovf_next;

	dtc_pkg::dtc_tctl_s c0, c1;
	assign c0.run = ctrl_reg[dtc_pkg::CTRL_T0_RUN];
	assign c0.gate = mode_reg[dtc_pkg::MODE_T0_GATE];
	assign c0.counter_sel = mode_reg[dtc_pkg::MODE_T0_CNT];
	assign c0.sysclk_sel = i_timer0_sysclk_select;
	assign c0.mode = dtc_pkg::dtc_mode_e'(mode_reg[dtc_pkg::MODE_T0_LSB +: 2]);
	assign c1.run = ctrl_reg[dtc_pkg::CTRL_T1_RUN];
	assign c1.gate = mode_reg[dtc_pkg::MODE_T1_GATE];
	assign c1.counter_sel = mode_reg[dtc_pkg::MODE_T1_CNT];
	assign c1.sysclk_sel = i_timer1_sysclk_select;
	assign c1.mode = dtc_pkg::dtc_mode_e'(mode_reg[dtc_pkg::MODE_T1_LSB +: 2]);

	// count strobes
	logic en0, en1, tick0, tick1, tick_time0, tick_time1, split;
	assign split = (c0.mode == dtc_pkg::DTC_MODE_SPLIT);
	assign en0 = c0.run && (!c0.gate || irq_act[0]);
	assign en1 = c1.run && (!c1.gate || irq_act[1]);
	assign tick_time0 = c0.sysclk_sel ? 1'b1 : pre_tick;
	assign tick_time1 = c1.sysclk_sel ? 1'b1 : pre_tick;
	assign tick0 = en0 && (c0.counter_sel ? fall[2] : tick_time0);
	// timer1 loses its external clock while timer0 is split
	assign tick1 = en1 && ((c1.counter_sel && !split) ? fall[3]
		: tick_time1);

	// software access decode: register write, or single-bit write
	function automatic logic [7:0] apply_wr(input logic [7:0] cur);
		logic [7:0] v;
		v = cur;
		if (i_bit_wr)
			v[i_bit_sel] = i_wdata[0];
		else
			v = i_wdata;
		return v;
	endfunction

	logic wr_any;
	assign wr_any = i_wr || i_bit_wr;

	always_comb begin
		logic [15:0] cnt;
		logic        ovf0, ovf0h, ovf1;
		cnt = '0;
		ovf0 = 1'b0;
		ovf0h = 1'b0;
		ovf1 = 1'b0;
		ctrl_next = ctrl_reg;
		mode_next = mode_reg;
		t0l_next = t0l_reg;
		t0h_next = t0h_reg;
		t1l_next = t1l_reg;
		t1h_next = t1h_reg;
		rdata_next = rdata_reg;

		// software writes first; hardware updates below override
		if (wr_any) begin
			case (i_addr)
			dtc_pkg::ADDR_CTRL:    ctrl_next = apply_wr(ctrl_reg);
			dtc_pkg::ADDR_MODE:    mode_next = apply_wr(mode_reg);
			dtc_pkg::ADDR_T0_LOW:  t0l_next = apply_wr(t0l_reg);
			dtc_pkg::ADDR_T1_LOW:  t1l_next = apply_wr(t1l_reg);
			dtc_pkg::ADDR_T0_HIGH: t0h_next = apply_wr(t0h_reg);
			dtc_pkg::ADDR_T1_HIGH: t1h_next = apply_wr(t1h_reg);
			default: ;
			endcase
		end

		// timer0: both bytes in 13- and 16-bit modes, low byte in reload and split
		if (tick0) begin
			case (c0.mode)
			dtc_pkg::DTC_MODE_13: begin
				cnt = {t0h_reg, 3'b000, t0l_reg[4:0]};
				ovf0 = ({t0h_reg, t0l_reg[4:0]} == 13'(dtc_pkg::MAX_13));
				{t0h_next, t0l_next[4:0]} = 13'({t0h_reg, t0l_reg[4:0]} + 1'b1);
			end
			dtc_pkg::DTC_MODE_16: begin
				cnt = {t0h_reg, t0l_reg} + 1'b1;
				ovf0 = (cnt == 16'h0000);
				{t0h_next, t0l_next} = cnt;
			end
			dtc_pkg::DTC_MODE_RELOAD: begin
				ovf0 = (t0l_reg == 8'hFF);
				t0l_next = ovf0 ? t0h_reg : 8'(t0l_reg + 1'b1);
			end
			default: begin
				ovf0 = (t0l_reg == 8'hFF);
				t0l_next = 8'(t0l_reg + 1'b1);
			end
			endcase
		end
		// split high byte: timer function only, on timer1 run bit
		if (split && c1.run && tick_time0) begin
			ovf0h = (t0h_reg == 8'hFF);
			t0h_next = 8'(t0h_reg + 1'b1);
		end

		// timer1
		if (tick1) begin
			case (c1.mode)
			dtc_pkg::DTC_MODE_13: begin
				ovf1 = ({t1h_reg, t1l_reg[4:0]} == 13'(dtc_pkg::MAX_13));
				{t1h_next, t1l_next[4:0]} = 13'({t1h_reg, t1l_reg[4:0]} + 1'b1);
			end
			dtc_pkg::DTC_MODE_16: begin
				cnt = {t1h_reg, t1l_reg} + 1'b1;
				ovf1 = (cnt == 16'h0000);
				{t1h_next, t1l_next} = cnt;
			end
			dtc_pkg::DTC_MODE_RELOAD: begin
				ovf1 = (t1l_reg == 8'hFF);
				t1l_next = ovf1 ? t1h_reg : 8'(t1l_reg + 1'b1);
			end
			default: ;
			endcase
		end

		// flag clears by vectoring, then hardware sets so sets win
		if (i_ack_timer0)
			ctrl_next[dtc_pkg::CTRL_T0_OVF] = 1'b0;
		if (i_ack_timer1)
			ctrl_next[dtc_pkg::CTRL_T1_OVF] = 1'b0;
		if (i_ack_ext0 && ctrl_reg[dtc_pkg::CTRL_X0_TYPE])
			ctrl_next[dtc_pkg::CTRL_X0_PEND] = 1'b0;
		if (i_ack_ext1 && ctrl_reg[dtc_pkg::CTRL_X1_TYPE])
			ctrl_next[dtc_pkg::CTRL_X1_PEND] = 1'b0;
		if (ovf0)
			ctrl_next[dtc_pkg::CTRL_T0_OVF] = 1'b1;
		// while split, only the timer0 high byte may raise this flag
		if (split ? ovf0h : ovf1)
			ctrl_next[dtc_pkg::CTRL_T1_OVF] = 1'b1;
		// level mode keeps setting while the input stays active
		if (ctrl_reg[dtc_pkg::CTRL_X0_TYPE] ? irq_edge[0] : irq_act[0])
			ctrl_next[dtc_pkg::CTRL_X0_PEND] = 1'b1;
		if (ctrl_reg[dtc_pkg::CTRL_X1_TYPE] ? irq_edge[1] : irq_act[1])
			ctrl_next[dtc_pkg::CTRL_X1_PEND] = 1'b1;

		// overflow pulse kept even while split so serial rates still run
		t1ovf_next = ovf1;

		if (i_rd) begin
			case (i_addr)
			dtc_pkg::ADDR_CTRL:    rdata_next = ctrl_reg;
			dtc_pkg::ADDR_MODE:    rdata_next = mode_reg;
			dtc_pkg::ADDR_T0_LOW:  rdata_next = t0l_reg;
			dtc_pkg::ADDR_T1_LOW:  rdata_next = t1l_reg;
			dtc_pkg::ADDR_T0_HIGH: rdata_next = t0h_reg;
			dtc_pkg::ADDR_T1_HIGH: rdata_next = t1h_reg;
			default:               rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			ctrl_reg <= dtc_pkg::RESET_BYTE;
			mode_reg <= dtc_pkg::RESET_BYTE;
			t0l_reg <= dtc_pkg::RESET_BYTE;
			t0h_reg <= dtc_pkg::RESET_BYTE;
			t1l_reg <= dtc_pkg::RESET_BYTE;
			t1h_reg <= dtc_pkg::RESET_BYTE;
			rdata_reg <= dtc_pkg::RESET_BYTE;
			t1ovf_reg <= 1'b0;
		end else if (i_ce) begin
			ctrl_reg <= ctrl_next;
			mode_reg <= mode_next;
			t0l_reg <= t0l_next;
			t0h_reg <= t0h_next;
			t1l_reg <= t1l_next;
			t1h_reg <= t1h_next;
			rdata_reg <= rdata_next;
			t1ovf_reg <= t1ovf_next;
		end
	end

	assign o_rdata = rdata_reg;
	assign o_timer_ctrl = ctrl_reg;
	assign o_timer1_overflow = t1ovf_reg;
endmodule
`default_nettype wire

// File: design/dtc_pkg.sv
// Purpose: shared constants and carriers for the dual timer control block
// Assumes: byte-wide special-function register port, 40 MHz system clock
// Notes:   offsets and bit positions are named once here
`default_nettype none
package dtc_pkg;
	// register addresses
	localparam logic [7:0] ADDR_CTRL     = 8'h88;
	localparam logic [7:0] ADDR_MODE     = 8'h89;
	localparam logic [7:0] ADDR_T0_LOW   = 8'h8A;
	localparam logic [7:0] ADDR_T1_LOW   = 8'h8B;
	localparam logic [7:0] ADDR_T0_HIGH  = 8'h8C;
	localparam logic [7:0] ADDR_T1_HIGH  = 8'h8D;
	localparam logic [7:0] RESET_BYTE    = 8'h00;
	// control register bit positions
	localparam int CTRL_T1_OVF   = 7;
	localparam int CTRL_T1_RUN   = 6;
	localparam int CTRL_T0_OVF   = 5;
	localparam int CTRL_T0_RUN   = 4;
	localparam int CTRL_X1_PEND  = 3;
	localparam int CTRL_X1_TYPE  = 2;
	localparam int CTRL_X0_PEND  = 1;
	localparam int CTRL_X0_TYPE  = 0;
	// mode register bit positions
	localparam int MODE_T1_GATE  = 7;
	localparam int MODE_T1_CNT   = 6;
	localparam int MODE_T1_LSB   = 4;
	localparam int MODE_T0_GATE  = 3;
	localparam int MODE_T0_CNT   = 2;
	localparam int MODE_T0_LSB   = 0;
	// prescale divide counts
	localparam int DIV_SYS_12    = 12;
	localparam int DIV_SYS_4     = 4;
	localparam int DIV_SYS_48    = 48;
	localparam int DIV_EXT_8     = 8;
	localparam logic [15:0] MAX_13 = 16'h1FFF;

	typedef enum logic [1:0] {
		DTC_MODE_13    = 2'b00,
		DTC_MODE_16    = 2'b01,
		DTC_MODE_RELOAD = 2'b10,
		DTC_MODE_SPLIT = 2'b11
	} dtc_mode_e;

	// per-timer controls from the register file, plus the clock select input
	typedef struct packed {
		logic      run;
		logic      gate;
		logic      counter_sel;
		logic      sysclk_sel;
		dtc_mode_e mode;
	} dtc_tctl_s;
endpackage
`default_nettype wire

// File: design/dtc_prescaler.sv
// Purpose: timer tick prescaler with four selectable divisors
// Assumes: external clock already synchronised, a rising edge pulse given
// Notes:   one tick pulse per divided period
`timescale 1ns/10ps
`default_nettype none
module dtc_prescaler #(
	parameter int CNT_W = 6
) (
	// clock and reset
	input  wire logic       i_mclk,
	input  wire logic       i_resetn,
	input  wire logic       i_ce,
	// control
	input  wire logic [1:0] i_sel,
	input  wire logic       i_ext_edge,
	// tick
	output logic            o_tick
);
	if (CNT_W < 6) begin : g_bad_width
		$error("prescaler counter too narrow");
	end

	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	logic             tick_reg;
	logic             tick_next;
	logic [CNT_W-1:0] last;
	logic             step;

	////////////////////////////////////////////////////////////////////
	always_comb begin
		case (i_sel)
		2'b00:   last = CNT_W'(dtc_pkg::DIV_SYS_12 - 1);
		2'b01:   last = CNT_W'(dtc_pkg::DIV_SYS_4 - 1);
		2'b10:   last = CNT_W'(dtc_pkg::DIV_SYS_48 - 1);
		default: last = CNT_W'(dtc_pkg::DIV_EXT_8 - 1);
		endcase
		// external source counts its own edges, not system cycles
		step = (i_sel == 2'b11) ? i_ext_edge : 1'b1;
		cnt_next = cnt_reg;
		tick_next = 1'b0;
		if (step) begin
			if (cnt_reg >= last) begin
				cnt_next = '0;
				tick_next = 1'b1;
			end else begin
				cnt_next = cnt_reg + 1'b1;
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			cnt_reg <= '0;
			tick_reg <= 1'b0;
		end else if (i_ce) begin
			cnt_reg <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign o_tick = tick_reg;
endmodule
`default_nettype wire

// File: verif/dtc_chk.sv
// Purpose: port-level checks of the timer control block
// Assumes: one clock domain; checks look only at enabled cycles, except the idle timer1 check
// Notes:   mode shadow mirrors byte and bit writes to the mode register
`timescale 1ns/10ps
`default_nettype none
module dtc_chk (
	// clock and reset
	input wire logic       i_mclk,
	input wire logic       i_resetn,
	// register port
	input wire logic       i_ce,
	input wire logic [7:0] i_addr,
	input wire logic       i_wr,
	input wire logic       i_bit_wr,
	input wire logic [2:0] i_bit_sel,
	input wire logic [7:0] i_wdata,
	input wire logic       i_rd,
	input wire logic [7:0] o_rdata,
	// acks and pins
	input wire logic       i_ack_timer0,
	input wire logic       i_ack_ext0,
	input wire logic       i_ext_irq0_pin,
	input wire logic       i_ext_irq0_polarity,
	// status
	input wire logic [7:0] o_timer_ctrl,
	input wire logic       o_timer1_overflow
);
	logic       ctl_wr;
	logic       run0;
	logic [7:0] mode_reg;
	logic [7:0] mode_next;
	assign ctl_wr = i_ce && (i_wr || i_bit_wr) && i_addr == dtc_pkg::ADDR_CTRL;
	assign run0 = o_timer_ctrl[4];
	always_comb begin
		mode_next = mode_reg;
		if (i_ce && i_wr && i_addr == dtc_pkg::ADDR_MODE)
			mode_next = i_wdata;
		else if (i_ce && i_bit_wr && i_addr == dtc_pkg::ADDR_MODE)
			mode_next[i_bit_sel] = i_wdata[0];
	end
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn)
			mode_reg <= 8'h00;
		else
			mode_reg <= mode_next;
	end
	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_resetn);
	// six quiet samples cover the two sync flops and the compare stage
	sequence s_quiet0;
		$stable(i_ext_irq0_pin) [*6];
	endsequence
	sequence s_active0;
		(i_ce && i_ext_irq0_pin == i_ext_irq0_polarity
			&& !o_timer_ctrl[0] && !ctl_wr) [*5];
	endsequence
	property p_byte_wr;
		i_ce && i_wr && i_addr == dtc_pkg::ADDR_CTRL
			|=> (o_timer_ctrl & 8'h55) == ($past(i_wdata) & 8'h55);
	endproperty
	a_byte_wr: assert property (p_byte_wr) else $error("byte write lost");
	property p_bit_wr;
		ctl_wr && i_bit_wr && !i_bit_sel[0] |=>
			((o_timer_ctrl >> $past(i_bit_sel)) & 8'h01) == ($past(i_wdata) & 8'h01);
	endproperty
	a_bit_wr: assert property (p_bit_wr) else $error("bit write lost");
	property p_ovf_ack;
		i_ce && i_ack_timer0 && !run0 && !$past(run0) && !ctl_wr
			|=> !o_timer_ctrl[5];
	endproperty
	a_ovf_ack: assert property (p_ovf_ack) else $error("overflow flag kept");
	property p_edge_ack;
		s_quiet0 ##0 (i_ce && i_ack_ext0 && o_timer_ctrl[0] && !ctl_wr)
			|=> !o_timer_ctrl[1];
	endproperty
	a_edge_ack: assert property (p_edge_ack) else $error("edge pending kept");
	property p_level_set;
		s_active0 |-> o_timer_ctrl[1];
	endproperty
	a_level_set: assert property (p_level_set) else $error("level not seen");
	property p_rd_mode;
		i_ce && i_rd && i_addr == dtc_pkg::ADDR_MODE |=> o_rdata == $past(mode_reg);
	endproperty
	a_rd_mode: assert property (p_rd_mode) else $error("mode read wrong");
	property p_unmapped;
		i_ce && i_rd && (i_addr < dtc_pkg::ADDR_CTRL || i_addr > dtc_pkg::ADDR_T1_HIGH)
			|=> o_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read");
	property p_t1_idle;
		(mode_reg[5:4] == 2'b11) [*3] |-> !o_timer1_overflow;
	endproperty
	a_t1_idle: assert property (p_t1_idle) else $error("idle timer1 fired");
endmodule
bind dtc_timer_ctrl dtc_chk u_chk (.i_mclk, .i_resetn, .i_ce, .i_addr, .i_wr,
	.i_bit_wr, .i_bit_sel, .i_wdata, .i_rd, .o_rdata, .i_ack_timer0, .i_ack_ext0,
	.i_ext_irq0_pin, .i_ext_irq0_polarity, .o_timer_ctrl, .o_timer1_overflow);
`default_nettype wire

// File: verif/dtc_pin_model.sv
// Purpose: pin side of the timer block: count, interrupt and clock pins
// Assumes: count pin idles high, edges at least two cycles apart
// Notes:   slow mode stretches each half period; oscillator runs free
`timescale 1ns/10ps
`default_nettype none
module dtc_pin_model (
	// clock
	input  wire logic       i_mclk,
	// requests
	input  wire logic       i_go,
	input  wire logic [3:0] i_num,
	input  wire logic       i_slow,
	input  wire logic [1:0] i_irq,
	// pins
	output logic      [1:0] o_irq_pin,
	output logic            o_cnt_pin,
	output logic            o_ext_clk,
	output logic            o_busy
);
	logic [1:0] div_reg = 2'b00;
	assign o_ext_clk = div_reg[1];
	initial begin
		o_cnt_pin = 1'b1;
		o_busy = 1'b0;
		o_irq_pin = 2'b11;
	end
	always @(posedge i_mclk) begin
		div_reg <= div_reg + 2'b01;
		o_irq_pin <= i_irq;
	end
	always @(posedge i_mclk) begin
		if (i_go) begin
			o_busy <= 1'b1;
			repeat (i_num) begin
				repeat (i_slow ? 5 : 2) @(posedge i_mclk);
				o_cnt_pin <= 1'b0;
				repeat (i_slow ? 5 : 2) @(posedge i_mclk);
				o_cnt_pin <= 1'b1;
			end
			o_busy <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// File: verif/tb_top.sv
// Purpose: self-checking bench of the dual timer control block
// Assumes: clock enable dropped only inside the prescale test
// Notes:   counts come from pulse totals, so pin latency does not matter
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic       i_mclk = 1'b0;
	logic       i_resetn = 1'b0;
	logic       i_ce = 1'b1;
	logic [7:0] i_addr = 8'h00;
	logic [7:0] i_wdata = 8'h00;
	logic [2:0] i_bit_sel = 3'h0;
	logic       i_wr = 1'b0, i_bit_wr = 1'b0, i_rd = 1'b0;
	logic       i_ack_timer0 = 1'b0, i_ack_timer1 = 1'b0;
	logic       i_ack_ext0 = 1'b0, i_ack_ext1 = 1'b0;
	logic       i_timer0_sysclk_select = 1'b0;
	logic [1:0] i_prescale_sel = 2'b00, pol = 2'b00, irq = 2'b11, irq_pin;
	logic       go = 1'b0, slow = 1'b0, cnt_pin, i_ext_clk, busy;
	logic [3:0] num = 4'h0;
	logic [7:0] o_rdata, o_timer_ctrl;
	logic       o_timer1_overflow;
	int         error_cnt = 0;
	int         num_checks = 0;
	always #12.5 i_mclk = ~i_mclk;
	dtc_timer_ctrl uut (.i_mclk, .i_resetn, .i_ce, .i_addr, .i_wr, .i_bit_wr,
		.i_bit_sel, .i_wdata, .i_rd, .o_rdata, .i_ack_timer0, .i_ack_timer1,
		.i_ack_ext0, .i_ack_ext1, .i_ext_irq0_polarity(pol[0]),
		.i_ext_irq1_polarity(pol[1]), .i_timer0_sysclk_select,
		.i_timer1_sysclk_select(1'b1), .i_prescale_sel, .i_ext_irq0_pin(irq_pin[0]),
		.i_ext_irq1_pin(irq_pin[1]), .i_timer0_ext_count_pin(cnt_pin),
		.i_timer1_ext_count_pin(cnt_pin), .i_ext_clk, .o_timer_ctrl,
		.o_timer1_overflow);
	dtc_pin_model pm (.i_mclk, .i_go(go), .i_num(num), .i_slow(slow), .i_irq(irq),
		.o_irq_pin(irq_pin), .o_cnt_pin(cnt_pin), .o_ext_clk(i_ext_clk), .o_busy(busy));
	////////////////////////////////////////////////////////////////////////
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_mclk);
		i_wr <= 1'b0;
		@(posedge i_mclk);
	endtask
	task automatic bit_wr(input logic [2:0] b, input logic v);
		i_addr <= dtc_pkg::ADDR_CTRL;
		i_bit_sel <= b;
		i_wdata <= {7'h00, v};
		i_bit_wr <= 1'b1;
		@(posedge i_mclk);
		i_bit_wr <= 1'b0;
		@(posedge i_mclk);
	endtask
	task automatic rd_reg(input logic [7:0] a);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		@(posedge i_mclk);
	endtask
	task automatic do_ack(input logic [3:0] v);
		{i_ack_ext1, i_ack_ext0, i_ack_timer1, i_ack_timer0} <= v;
		@(posedge i_mclk);
		{i_ack_ext1, i_ack_ext0, i_ack_timer1, i_ack_timer0} <= 4'h0;
		@(posedge i_mclk);
	endtask
	task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	// prescaler phase is free, so a small window is allowed
	task automatic chk_near(input string n, input int e, input logic [15:0] g);
		num_checks++;
		if ($isunknown(g) || g > e + 3 || g + 3 < e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %0d seen %0d", n, e, g);
		end
	endtask
	function automatic logic [16:0] exp_cnt(input logic [1:0] m,
		input logic [7:0] th, input logic [7:0] tl, input int n);
		logic [16:0] r;
		logic [12:0] c;
		r = {1'b0, th, tl};
		repeat (n) begin
			c = {r[15:8], r[4:0]} + 13'h0001;
			if (m == 2'b00) begin
				r[16] |= c == 13'h0000;
				{r[15:8], r[4:0]} = c;
			end else if (m == 2'b01) begin
				r[16] |= r[15:0] == 16'hFFFF;
				r[15:0] = r[15:0] + 16'h0001;
			end else begin
				r[16] |= r[7:0] == 8'hFF;
				r[7:0] = (m == 2'b10 && r[7:0] == 8'hFF) ? r[15:8] : r[7:0] + 8'h01;
			end
		end
		return r;
	endfunction
	function automatic int exp_ticks(input int k);
		int d[4] = '{dtc_pkg::DIV_SYS_12, dtc_pkg::DIV_SYS_4, dtc_pkg::DIV_SYS_48,
			dtc_pkg::DIV_EXT_8 * 4};
		// 962 running edges less the 100 frozen ones
		return (k == 4) ? 862 : 862 / d[k];
	endfunction
	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge i_mclk);
		error_cnt++;
		$display("CHECK FAILED watchdog expected done seen hang");
		final_report();
	end
	initial begin
		logic [7:0] d, th, tl;
		logic [16:0] e;
		logic [1:0] m;
		logic g, a, p;
		int n, k, x;
		void'($urandom(83));
		repeat (3) @(posedge i_mclk);
		i_resetn <= 1'b1;
		@(posedge i_mclk);
		for (k = 8'h88; k <= 8'h8E; k++) begin
			rd_reg(k[7:0]);
			chk8("reset", 8'h00, o_rdata);
		end
		repeat (6) begin
			d = 8'($urandom);
			wr_reg(dtc_pkg::ADDR_MODE, d);
			rd_reg(dtc_pkg::ADDR_MODE);
			chk8("mode", d, o_rdata);
			wr_reg(dtc_pkg::ADDR_CTRL, d & 8'h55);
			chk8("ctrl", d & 8'h55, o_timer_ctrl & 8'h55);
		end
		for (k = 0; k < 8; k += 2) begin
			bit_wr(k[2:0], 1'b1);
			chk8("bit", 8'h01, (o_timer_ctrl >> k) & 8'h01);
		end
		wr_reg(dtc_pkg::ADDR_CTRL, 8'h00);
		$display("test registers done");
		// modes 00 to 11 on the count pin, gate off then gate on
		for (k = 0; k < 12; k++) begin
			m = k[1:0];
			g = k >= 8;
			a = 1'($urandom);
			p = 1'($urandom);
			pol[0] <= p;
			irq[0] <= ~(a ^ p);
			th = (m == 2'b10) ? 8'($urandom) : 8'hFF;
			tl = 8'hF8 | 8'($urandom_range(7));
			n = $urandom_range(9, 2);
			wr_reg(dtc_pkg::ADDR_MODE, {4'h0, g, 1'b1, m});
			wr_reg(dtc_pkg::ADDR_T0_HIGH, th);
			wr_reg(dtc_pkg::ADDR_T0_LOW, tl);
			wr_reg(dtc_pkg::ADDR_CTRL, 8'h10);
			num <= n[3:0];
			slow <= 1'($urandom);
			go <= 1'b1;
			@(posedge i_mclk);
			go <= 1'b0;
			repeat (2) @(posedge i_mclk);
			for (x = 0; x < 200 && busy !== 1'b0; x++) @(posedge i_mclk);
			repeat (6) @(posedge i_mclk);
			e = exp_cnt(m, th, tl, (g && !a) ? 0 : n);
			chk8("ovf", {7'h00, e[16]}, {7'h00, o_timer_ctrl[5]});
			rd_reg(dtc_pkg::ADDR_T0_LOW);
			chk8("low", e[7:0], o_rdata);
			rd_reg(dtc_pkg::ADDR_T0_HIGH);
			chk8("high", e[15:8], o_rdata);
			bit_wr(3'h4, 1'b0);
			do_ack(4'h1);
			chk8("ack", 8'h00, o_timer_ctrl & 8'h20);
			wr_reg(dtc_pkg::ADDR_CTRL, 8'h00);
		end
		$display("test counting done");
		i_timer0_sysclk_select <= 1'b1;
		wr_reg(dtc_pkg::ADDR_MODE, 8'h33);
		wr_reg(dtc_pkg::ADDR_T0_HIGH, 8'hF0);
		wr_reg(dtc_pkg::ADDR_CTRL, 8'h40);
		for (x = 0; x < 100 && o_timer_ctrl[7] !== 1'b1; x++) @(posedge i_mclk);
		chk8("split", 8'h80, o_timer_ctrl & 8'hA0);
		wr_reg(dtc_pkg::ADDR_CTRL, 8'h00);
		// timer1 reload on the system clock: flag and one-cycle pulse
		wr_reg(dtc_pkg::ADDR_MODE, 8'h20);
		wr_reg(dtc_pkg::ADDR_T1_HIGH, 8'hF0);
		wr_reg(dtc_pkg::ADDR_T1_LOW, 8'hF0);
		wr_reg(dtc_pkg::ADDR_CTRL, 8'h40);
		for (x = 0; x < 40 && o_timer1_overflow !== 1'b1; x++) @(posedge i_mclk);
		d = {o_timer_ctrl[7], 6'h00, o_timer1_overflow};
		chk8("t1ovf", 8'h81, d);
		@(posedge i_mclk);
		chk8("t1pulse", 8'h00, {7'h00, o_timer1_overflow});
		bit_wr(3'h6, 1'b0);
		do_ack(4'h2);
		chk8("ack1", 8'h00, o_timer_ctrl & 8'h80);
		wr_reg(dtc_pkg::ADDR_MODE, 8'h01);
		for (k = 0; k < 5; k++) begin
			i_prescale_sel <= k[1:0];
			i_timer0_sysclk_select <= k == 4;
			wr_reg(dtc_pkg::ADDR_T0_LOW, 8'h00);
			wr_reg(dtc_pkg::ADDR_T0_HIGH, 8'h00);
			wr_reg(dtc_pkg::ADDR_CTRL, 8'h10);
			// frozen cycles must not count anywhere in the timer path
			i_ce <= 1'b0;
			repeat (100) @(posedge i_mclk);
			i_ce <= 1'b1;
			repeat (860) @(posedge i_mclk);
			wr_reg(dtc_pkg::ADDR_CTRL, 8'h00);
			rd_reg(dtc_pkg::ADDR_T0_LOW);
			d = o_rdata;
			rd_reg(dtc_pkg::ADDR_T0_HIGH);
			chk_near("scale", exp_ticks(k), {o_rdata, d});
		end
		$display("test prescale done");
		// both inputs, level then edge type, random sense
		for (k = 0; k < 4; k++) begin
			x = k / 2;
			p = 1'($urandom);
			pol[x] <= p;
			irq[x] <= ~p;
			repeat (8) @(posedge i_mclk);
			wr_reg(dtc_pkg::ADDR_CTRL, 8'((k % 2) << (2 * x)));
			chk8("idle", 8'h00, (o_timer_ctrl >> (2 * x + 1)) & 8'h01);
			irq[x] <= p;
			repeat (8) @(posedge i_mclk);
			chk8("set", 8'h01, (o_timer_ctrl >> (2 * x + 1)) & 8'h01);
			irq[x] <= ~p;
			repeat (8) @(posedge i_mclk);
			do_ack(4'(4 << x));
			chk8("vec", 8'(1 - k % 2), (o_timer_ctrl >> (2 * x + 1)) & 8'h01);
			wr_reg(dtc_pkg::ADDR_CTRL, 8'h00);
			chk8("clr", 8'h00, o_timer_ctrl & 8'h0A);
		end
		$display("test interrupts done");
		final_report();
	end
endmodule
`default_nettype wire
